/* File: src/shifter_pkg.sv */
// shared constants and carrier types for the latched serial-to-parallel shifter
// assumes a single 40 MHz system clock; pins are sampled, not used as clocks
package shifter_pkg;
    localparam int STAGES = 8;
    localparam int EARLY_TAP = 6;
    localparam int LATE_TAP = 7;
    localparam int SYNC_DEPTH = 3;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] STAGE_RESET = 8'h00;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    // one sampled pin event: edge kind plus the data pin at that moment
    typedef struct packed {
        logic rise;
        logic fall;
        logic data;
    } pin_event_t;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_HIGH = 2'b01,
        SH_LOW = 2'b10
    } clk_state_t;
endpackage : shifter_pkg

/* File: src/event_fifo.sv */
// parameterised valid/ready fifo for pin events
// assumes same clock domain on both sides; asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module event_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : event_fifo
`default_nettype wire

/* File: src/latched_shifter.sv */
// serial-in shifter with transparent storage latch and three-state parallel outputs
// pins arrive asynchronously and are sampled on clk; no host-visible registers
`timescale 1ns/1ps
`default_nettype none
module latched_shifter #(
    parameter int STAGES = shifter_pkg::STAGES,
    parameter int FIFO_DEPTH = shifter_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic storage_strobe,
    input wire logic output_enable,
    output logic [STAGES-1:0] parallel_out,
    output logic [STAGES-1:0] parallel_oe,
    output logic early_serial_out,
    output logic late_serial_out,
    output logic overrun
);
    localparam int SD = shifter_pkg::SYNC_DEPTH;

    // three-stage samplers; a change counts once stages two and three agree
    logic [SD-1:0] clk_sync_r;
    logic [SD-1:0] dat_sync_r;
    logic [SD-1:0] str_sync_r;
    logic [SD-1:0] oe_sync_r;
    logic clk_level_r;
    logic dat_level_r;
    logic str_level_r;
    logic oe_level_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clk_sync_r <= shifter_pkg::SYNC_RESET;
            dat_sync_r <= shifter_pkg::SYNC_RESET;
            str_sync_r <= shifter_pkg::SYNC_RESET;
            oe_sync_r <= shifter_pkg::SYNC_RESET;
        end
        else
        begin
            clk_sync_r <= {clk_sync_r[SD-2:0], shift_clock};
            dat_sync_r <= {dat_sync_r[SD-2:0], serial_in};
            str_sync_r <= {str_sync_r[SD-2:0], storage_strobe};
            oe_sync_r <= {oe_sync_r[SD-2:0], output_enable};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clk_level_r <= 1'b0;
            dat_level_r <= 1'b0;
            str_level_r <= 1'b0;
            oe_level_r <= 1'b0;
        end
        else
        begin
            if (clk_sync_r[1] == clk_sync_r[2])
            begin
                clk_level_r <= clk_sync_r[2];
            end
            if (dat_sync_r[1] == dat_sync_r[2])
            begin
                dat_level_r <= dat_sync_r[2];
            end
            if (str_sync_r[1] == str_sync_r[2])
            begin
                str_level_r <= str_sync_r[2];
            end
            if (oe_sync_r[1] == oe_sync_r[2])
            begin
                oe_level_r <= oe_sync_r[2];
            end
        end
    end

    // edge detection on the filtered shift clock
    shifter_pkg::clk_state_t clk_state_r;
    shifter_pkg::pin_event_t ev_in;
    shifter_pkg::pin_event_t ev_out;
    logic ev_valid;
    logic ev_in_ready;
    logic ev_out_valid;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clk_state_r <= shifter_pkg::SH_IDLE;
        end
        else
        begin
            case (clk_state_r)
                shifter_pkg::SH_IDLE: clk_state_r <= clk_level_r ? shifter_pkg::SH_HIGH : shifter_pkg::SH_LOW;
                shifter_pkg::SH_HIGH: clk_state_r <= clk_level_r ? shifter_pkg::SH_HIGH : shifter_pkg::SH_LOW;
                shifter_pkg::SH_LOW: clk_state_r <= clk_level_r ? shifter_pkg::SH_HIGH : shifter_pkg::SH_LOW;
                default: clk_state_r <= shifter_pkg::SH_IDLE;
            endcase
        end
    end

    // data is captured with the edge, so fifo latency cannot skew setup
    always_comb
    begin
        ev_in.rise = (clk_state_r == shifter_pkg::SH_LOW) && clk_level_r;
        ev_in.fall = (clk_state_r == shifter_pkg::SH_HIGH) && !clk_level_r;
        ev_in.data = dat_level_r;
        ev_valid = ev_in.rise || ev_in.fall;
    end

    // the shift engine drains one event per cycle; the fifo absorbs bursts
    event_fifo #(
        .WIDTH($bits(shifter_pkg::pin_event_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_events (
        .clk(clk),
        .rst(rst),
        .in_valid(ev_valid),
        .in_ready(ev_in_ready),
        .in_data(ev_in),
        .out_valid(ev_out_valid),
        .out_ready(1'b1),
        .out_data(ev_out)
    );

    // a lost edge can only come from pin edges faster than sampling; flag it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            overrun <= 1'b0;
        end
        else if (ev_valid && !ev_in_ready)
        begin
            overrun <= 1'b1;
        end
    end

    logic [STAGES-1:0] stage_r;
    logic [STAGES-1:0] stage_nxt;
    logic [STAGES-1:0] storage_r;
    logic take_rise;
    logic take_fall;

    assign take_rise = ev_out_valid && ev_out.rise;
    assign take_fall = ev_out_valid && ev_out.fall;
    assign stage_nxt = {stage_r[STAGES-2:0], ev_out.data};

    // shift path, independent of strobe and output enable
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage_r <= shifter_pkg::STAGE_RESET;
        end
        else if (take_rise)
        begin
            stage_r <= stage_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            early_serial_out <= 1'b0;
        end
        else if (take_rise)
        begin
            early_serial_out <= stage_r[shifter_pkg::EARLY_TAP];
        end
    end

    // last stage again, half a shift-clock period later for cascading
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            late_serial_out <= 1'b0;
        end
        else if (take_fall)
        begin
            late_serial_out <= stage_r[shifter_pkg::LATE_TAP];
        end
    end

    // transparent latch: include the same-cycle shift so the follow is exact
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            storage_r <= shifter_pkg::STAGE_RESET;
        end
        else if (str_level_r)
        begin
            storage_r <= take_rise ? stage_nxt : stage_r;
        end
        // strobe low: hold
    end

    // pins float via enable; design files never drive high impedance
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            parallel_out <= shifter_pkg::STAGE_RESET;
            parallel_oe <= '0;
        end
        else
        begin
            parallel_out <= (str_level_r && take_rise) ? stage_nxt : (str_level_r ? stage_r : storage_r);
            parallel_oe <= {STAGES{oe_level_r}};
        end
    end
endmodule : latched_shifter
`default_nettype wire

/* File: dv/latched_shifter_asserts.sv */
// port-level checker for the latched shifter
// assumes one clk domain and pins paced by the host model
`timescale 1ns/1ps
`default_nettype none
module latched_shifter_asserts #(
    parameter int STAGES = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic storage_strobe,
    input wire logic output_enable,
    input wire logic [STAGES-1:0] parallel_out,
    input wire logic [STAGES-1:0] parallel_oe,
    input wire logic early_serial_out,
    input wire logic late_serial_out,
    input wire logic overrun
);
    logic [3:0] rise_age_r;
    logic [3:0] fall_age_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ages saturate, so an update long after its edge still fails
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rise_age_r <= 4'hf;
        else if ($rose(shift_clock))
            rise_age_r <= 4'h0;
        else if (rise_age_r != 4'hf)
            rise_age_r <= rise_age_r + 4'h1;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            fall_age_r <= 4'hf;
        else if ($fell(shift_clock))
            fall_age_r <= 4'h0;
        else if (fall_age_r != 4'hf)
            fall_age_r <= fall_age_r + 4'h1;
    end
    a_oe_on: assert property (output_enable [*8] |-> parallel_oe == '1)
        else $error("parallel pins not driven");
    a_oe_off: assert property (!output_enable [*8] |-> parallel_oe == '0)
        else $error("parallel pins not floated");
    a_oe_uniform: assert property (parallel_oe == '0 || parallel_oe == '1)
        else $error("parallel enables disagree");
    a_early_on_rise: assert property ($changed(early_serial_out) |-> rise_age_r inside {[2:11]})
        else $error("early output moved away from a rise");
    a_late_on_fall: assert property ($changed(late_serial_out) |-> fall_age_r inside {[2:11]})
        else $error("late output moved away from a fall");
    a_serial_split: assert property ($changed(early_serial_out) |-> $stable(late_serial_out))
        else $error("serial outputs moved together");
    a_strobe_hold: assert property (!storage_strobe [*8] |-> $stable(parallel_out))
        else $error("storage changed with strobe low");
    a_oe_keeps: assert property ($changed(output_enable) |=> $stable(parallel_out) [*4])
        else $error("enable change altered storage");
    // host paces pins well below the sampling rate, so no edge may be lost
    a_no_overrun: assert property (!overrun)
        else $error("shift clock edge lost");
    cover property ($changed(early_serial_out));
    cover property ($changed(late_serial_out));
    cover property ($rose(parallel_oe[0]));
    cover property (storage_strobe && $changed(parallel_out));
endmodule : latched_shifter_asserts
bind latched_shifter latched_shifter_asserts #(.STAGES(STAGES)) latched_shifter_asserts_i (.clk(clk), .rst(rst),
    .shift_clock(shift_clock), .serial_in(serial_in), .storage_strobe(storage_strobe), .output_enable(output_enable),
    .parallel_out(parallel_out), .parallel_oe(parallel_oe), .early_serial_out(early_serial_out),
    .late_serial_out(late_serial_out), .overrun(overrun));
`default_nettype wire

/* File: dv/host_model.sv */
// host controller model: drives serial data, shift clock and strobe pins
// assumes clk from the bench; pins change only on its falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    output logic shift_clock,
    output logic serial_in,
    output logic storage_strobe
);
    // six cycles a phase keeps well clear of the sampler's filter
    localparam int PHASE = 6;
    initial
    begin
        shift_clock = 1'b0;
        serial_in = 1'b0;
        storage_strobe = 1'b0;
    end
    task automatic rise_bit(input logic b);
        @(negedge clk);
        serial_in = b;
        repeat (PHASE - 1) @(negedge clk);
        shift_clock = 1'b1;
    endtask : rise_bit
    task automatic fall_bit(input logic b);
        repeat (PHASE) @(negedge clk);
        shift_clock = 1'b0;
        serial_in = ~b; // invert after the fall, so no stale level
    endtask : fall_bit
    task automatic set_strobe(input logic v);
        @(negedge clk);
        storage_strobe = v;
        repeat (12) @(negedge clk);
    endtask : set_strobe
endmodule : host_model
`default_nettype wire

/* File: dv/latched_shifter_tb.sv */
// self-checking bench for the latched shifter
// assumes host_model drives the shift pins; bench drives rst and enable
`timescale 1ns/1ps
`default_nettype none
module latched_shifter_tb;
    logic clk;
    logic rst;
    logic output_enable;
    logic shift_clock;
    logic serial_in;
    logic storage_strobe;
    logic [7:0] parallel_out;
    logic [7:0] parallel_oe;
    logic early_serial_out;
    logic late_serial_out;
    logic overrun;
    int err_total;
    int check_count;
    host_model host_model_i (.clk(clk), .shift_clock(shift_clock), .serial_in(serial_in),
        .storage_strobe(storage_strobe));
    latched_shifter latched_shifter_i (.clk(clk), .rst(rst), .shift_clock(shift_clock), .serial_in(serial_in),
        .storage_strobe(storage_strobe), .output_enable(output_enable), .parallel_out(parallel_out),
        .parallel_oe(parallel_oe), .early_serial_out(early_serial_out), .late_serial_out(late_serial_out),
        .overrun(overrun));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // first bit out ends in the top stage
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
        begin
            host_model_i.rise_bit(v[i]);
            host_model_i.fall_bit(v[i]);
        end
        repeat (12) @(negedge clk);
    endtask : send_byte
    task automatic test_hold_then_load();
        output_enable = 1'b1;
        send_byte(8'ha5);
        check(parallel_out, 8'h00);
        host_model_i.set_strobe(1'b1);
        host_model_i.set_strobe(1'b0);
        check(parallel_out, 8'ha5);
        check(parallel_oe, 8'hff);
    endtask : test_hold_then_load
    task automatic test_serial_timing();
        host_model_i.set_strobe(1'b1);
        for (int i = 7; i >= 1; i--)
        begin
            host_model_i.rise_bit(i[0] ^ i[1]);
            host_model_i.fall_bit(i[0] ^ i[1]);
        end
        host_model_i.rise_bit(1'b0);
        host_model_i.fall_bit(1'b0);
        repeat (4) @(negedge clk);
        check(8'(early_serial_out), 8'h00);
        check(8'(late_serial_out), 8'h01);
        repeat (8) @(negedge clk);
        check(8'(late_serial_out), 8'h00);
        check(parallel_out, 8'h66);
        host_model_i.set_strobe(1'b0);
    endtask : test_serial_timing
    task automatic test_enable_off();
        @(negedge clk);
        output_enable = 1'b0;
        repeat (12) @(negedge clk);
        check(parallel_oe, 8'h00);
        check(parallel_out, 8'h66);
        send_byte(8'h81);
        host_model_i.set_strobe(1'b1);
        host_model_i.set_strobe(1'b0);
        check(8'({early_serial_out, late_serial_out}), 8'h03);
        output_enable = 1'b1;
        repeat (12) @(negedge clk);
        check(parallel_oe, 8'hff);
        check(parallel_out, 8'h81);
        check(8'(overrun), 8'h00);
    endtask : test_enable_off
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (6000) @(posedge clk);
        err_total++;
        complete_run();
    end
    initial
    begin
        err_total = 0;
        check_count = 0;
        rst = 1'b1;
        output_enable = 1'b0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        check(parallel_oe, 8'h00);
        test_hold_then_load();
        test_serial_timing();
        test_enable_off();
        complete_run();
    end
endmodule : latched_shifter_tb
`default_nettype wire
